// ==== include/prog_loader_pkg.sv ====
// constants of the serial program loader: opcodes, fields, sizes, timing
// assumes a 50 MHz ref_clk; times are given in microseconds
package prog_loader_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_MHZ       = 50;
  localparam int unsigned PROG_WAIT_US  = 4000; // shortest program delay
  localparam int unsigned ERASE_WAIT_US = 4000; // shortest erase delay
  // longest self-timed cycles that still fit inside the host's wait
  localparam int unsigned PROG_WAIT_CYC  = PROG_WAIT_US * CLK_MHZ;
  localparam int unsigned ERASE_WAIT_CYC = ERASE_WAIT_US * CLK_MHZ;
  localparam int unsigned BUSY_W         = 24;

  // ----------------------------------------------------------------
  // memory sizes and address fields
  // ----------------------------------------------------------------
  localparam int unsigned PMEM_BYTES = 1024; // 512 words, two bytes each
  localparam int unsigned PMEM_AW    = 10;   // word address 9 bits + byte sel
  localparam int unsigned DMEM_BYTES = 64;
  localparam int unsigned DMEM_AW    = 6;
  localparam int unsigned HSEL_BIT   = 3;    // high/low byte select in byte 1
  localparam int unsigned FIFO_DEPTH = 8;
  localparam int unsigned JOB_W      = 1 + PMEM_AW + 8;
  localparam logic        TGT_PMEM   = 1'b0;
  localparam logic        TGT_DMEM   = 1'b1;

  // ----------------------------------------------------------------
  // instruction bytes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_ESCAPE  = 8'hAC; // enable, erase, lock, fuse
  localparam logic [7:0] OP_ENABLE2 = 8'h53;
  localparam logic [2:0] SUB_ERASE  = 3'h4;  // byte 2 bits 7..5
  localparam logic [2:0] SUB_FUSE   = 3'h5;
  localparam logic [4:0] SUB_LOCK   = 5'h1f; // byte 2 bits 7..3, bit 0 set
  localparam logic [7:0] OP_HSEL_MASK = 8'hf7;
  localparam logic [7:0] OP_PRD     = 8'h20;
  localparam logic [7:0] OP_PWR     = 8'h40;
  localparam logic [7:0] OP_DRD     = 8'ha0;
  localparam logic [7:0] OP_DWR     = 8'hc0;
  localparam logic [7:0] OP_LOCK_RD = 8'h58;
  localparam logic [7:0] OP_SIG_RD  = 8'h30;
  localparam logic [7:0] OP_CAL_RD  = 8'h38;
  localparam logic [7:0] OP_FUSE_RD = 8'h50;

  // ----------------------------------------------------------------
  // reset and fill values
  // ----------------------------------------------------------------
  localparam logic [7:0]  BYTE_ERASED = 8'hff;
  localparam logic [7:0]  FUSE_RST    = 8'hff; // all fuses unprogrammed
  localparam logic [1:0]  LOCK_RST    = 2'h3;  // both lock bits unprogrammed
  localparam logic [1:0]  LOCK_MODE3  = 2'h0;
  localparam logic [31:0] SIG_RST     = 32'h1234_56ff; // arbitrary value
  localparam logic [7:0]  CAL_RST     = 8'h80;         // arbitrary value

endpackage

// ==== rtl/job_fifo.sv ====
// synchronous fifo for write jobs, valid/ready on both sides
// assumes one clock and a synchronous active-high reset
`timescale 1ns/100ps
`default_nettype none
module job_fifo #(
  parameter int unsigned WIDTH = 19,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             ref_clk,
  input  wire logic             rst,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);
  localparam int unsigned AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wrPtr;
    logic [AW-1:0] rdPtr;
    logic [AW:0]   count;
  } fifo_s;

  fifo_s s_q, s_d;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push, pop;

  // ----------------------------------------------------------------
  // pointers and fill level
  // ----------------------------------------------------------------
  always_comb begin
    inReady  = (s_q.count != (AW+1)'(DEPTH));
    outValid = (s_q.count != '0);
    outData  = mem[s_q.rdPtr];
    push     = inValid && inReady;
    pop      = outValid && outReady;
    s_d      = s_q;
    if (push) begin
      s_d.wrPtr = (s_q.wrPtr == AW'(DEPTH-1)) ? '0 : s_q.wrPtr + 1'b1;
    end
    if (pop) begin
      s_d.rdPtr = (s_q.rdPtr == AW'(DEPTH-1)) ? '0 : s_q.rdPtr + 1'b1;
    end
    if (push && !pop) begin
      s_d.count = s_q.count + 1'b1;
    end else if (pop && !push) begin
      s_d.count = s_q.count - 1'b1;
    end
  end

  // state register
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // storage, written on every accepted push
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[s_q.wrPtr] <= inData;
    end
  end

endmodule
`default_nettype wire

// ==== rtl/serial_program_loader.sv ====
// serial programming port: four-byte instruction interpreter with memories
// assumes pins arrive asynchronously; link clock is sampled by ref_clk
//
// What this block does
// - program and erase work only after the enable instruction with reset low
// - inbound bits taken on rising link clock, outbound shifted on falling
// - enable is AC, 53, two free bytes, honoured only while reset low
// - second enable byte echoes during third byte; host sends all four
// - chip erase AC, 100x sets program and data arrays to all ones
// - data byte write is self-timed and erases the byte itself
// - program memory 512 words, 9-bit address; data memory 64 bytes
// - program read 0010 H000, address in bytes two and three, data in four
// - program write 0100 H000, same address fields, data in byte four
// - data read A0, 6-bit address in byte three, value out in byte four
// - data write C0, 6-bit address in byte three, data in byte four
// - reading a byte being programmed gives all ones until done
// - lock write AC, 1111 1xx1; a zero programs that lock bit
// - lock read 58 returns lock bits in bits 2 and 1 of byte four
// - signature read 30, index in byte three; hidden in lock mode 3
// - fuse write AC, 101x, byte four holds the eight fuse bits
// - fuse read 50 returns fuse bits in byte four, same order
// - reset released high ends programming mode, normal run begins
`timescale 1ns/100ps
`default_nettype none
module serial_program_loader #(
  parameter int unsigned PROG_WAIT  = prog_loader_pkg::PROG_WAIT_CYC,
  parameter int unsigned ERASE_WAIT = prog_loader_pkg::ERASE_WAIT_CYC,
  parameter logic [31:0] SIG_BYTES  = prog_loader_pkg::SIG_RST, // arbitrary
  parameter logic [7:0]  CAL_BYTE   = prog_loader_pkg::CAL_RST  // arbitrary
) (
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       sckPin,
  input  wire logic       mosiPin,
  input  wire logic       resetPinN,
  output logic            miso,
  output logic            progEnabled,
  output logic            writeBusy,
  output logic            normalRun,
  output logic [7:0]      fuseBits,
  output logic [1:0]      lockBits
);
  import prog_loader_pkg::*;

  typedef struct packed {
    logic [1:0]        sckS;
    logic [1:0]        mosiS;
    logic [1:0]        rstS;
    logic              sckOld;
    logic [4:0]        bitCnt;
    logic [31:0]       rxSh;
    logic [7:0]        txSh;
    logic              miso;
    logic              progEn;
    logic              normalRun;
    logic [1:0]        lock;
    logic [7:0]        fuse;
    logic [BUSY_W-1:0] busyCnt;
    logic              busy;
    logic              jobOn;
    logic              jobTgt;
    logic [PMEM_AW-1:0] jobAddr;
    logic [7:0]        jobData;
  } st_s;

  st_s s_q, s_d;

  logic [7:0] pmem [PMEM_BYTES];
  logic [7:0] dmem [DMEM_BYTES];

  logic             rise, fall, exec, lastRead;
  logic [31:0]      word;
  logic [7:0]       b1, b2, b3, b4, rdByte;
  logic [PMEM_AW-1:0] pAddr;
  logic [DMEM_AW-1:0] dAddr;
  logic             isEnable, isErase, isFuseWr, isLockWr;
  logic             isPwr, isDwr, pollHit;
  logic             eraseNow, commit;
  logic             jobInValid, jobInReady, jobOutValid, jobOutReady;
  logic [JOB_W-1:0] jobInData, jobOutData;

  // ----------------------------------------------------------------
  // instruction view: the word as it stands after the current bit
  // ----------------------------------------------------------------
  always_comb begin
    rise     = s_q.sckS[1] && !s_q.sckOld;
    fall     = !s_q.sckS[1] && s_q.sckOld;
    word     = {s_q.rxSh[30:0], s_q.mosiS[1]};
    exec     = rise && (s_q.bitCnt == 5'h1f);
    lastRead = rise && (s_q.bitCnt == 5'h17);
    // byte 1 sits at 23:16 before the last byte, at 31:24 on exec
    b1       = exec ? word[31:24] : word[23:16];
    b2       = exec ? word[23:16] : word[15:8];
    b3       = exec ? word[15:8]  : word[7:0];
    b4       = word[7:0];
    pAddr    = {b2[0], b3, b1[HSEL_BIT]};
    dAddr    = b3[DMEM_AW-1:0];
    isEnable = (b1 == OP_ESCAPE) && (b2 == OP_ENABLE2);
    isErase  = (b1 == OP_ESCAPE) && (b2[7:5] == SUB_ERASE);
    isFuseWr = (b1 == OP_ESCAPE) && (b2[7:5] == SUB_FUSE);
    isLockWr = (b1 == OP_ESCAPE) && (b2[7:3] == SUB_LOCK) && b2[0];
    isPwr    = (b1 & OP_HSEL_MASK) == OP_PWR;
    isDwr    = b1 == OP_DWR;
  end

  // ----------------------------------------------------------------
  // byte four answer for read instructions, with data polling
  // ----------------------------------------------------------------
  always_comb begin
    pollHit = 1'b0;
    rdByte  = b3; // echo of the byte just taken
    if (s_q.progEn) begin
      if ((b1 & OP_HSEL_MASK) == OP_PRD) begin
        pollHit = s_q.jobOn && s_q.jobTgt == TGT_PMEM && s_q.jobAddr == pAddr;
        rdByte  = pmem[pAddr];
      end else if (b1 == OP_DRD) begin
        pollHit = s_q.jobOn && s_q.jobTgt == TGT_DMEM
                  && s_q.jobAddr == PMEM_AW'(dAddr);
        rdByte  = dmem[dAddr];
      end else if (b1 == OP_LOCK_RD) begin
        rdByte  = {5'h00, s_q.lock, 1'b0};
      end else if (b1 == OP_SIG_RD) begin
        rdByte  = (s_q.lock == LOCK_MODE3) ? 8'h00 : SIG_BYTES[8*b3[7:6] +: 8];
      end else if (b1 == OP_CAL_RD) begin
        rdByte  = CAL_BYTE;
      end else if (b1 == OP_FUSE_RD) begin
        rdByte  = s_q.fuse;
      end
      if (pollHit) begin
        rdByte  = BYTE_ERASED;
      end
    end
  end

  // ----------------------------------------------------------------
  // write jobs and erase decisions
  // ----------------------------------------------------------------
  always_comb begin
    eraseNow    = exec && s_q.progEn && !s_q.rstS[1] && isErase;
    jobInValid  = exec && s_q.progEn && !s_q.rstS[1] && (isPwr || isDwr);
    jobInData   = isPwr ? {TGT_PMEM, pAddr, b4}
                        : {TGT_DMEM, PMEM_AW'(dAddr), b4};
    jobOutReady = !s_q.busy && !eraseNow;
    commit      = s_q.jobOn && (s_q.busyCnt == 24'h00_0001);
  end

  // ----------------------------------------------------------------
  // next state: synchronisers, shifter, control, self-timed writer
  // ----------------------------------------------------------------
  always_comb begin
    s_d       = s_q;
    s_d.sckS  = {s_q.sckS[0], sckPin};
    s_d.mosiS = {s_q.mosiS[0], mosiPin};
    s_d.rstS  = {s_q.rstS[0], resetPinN};
    s_d.sckOld = s_q.sckS[1];
    if (s_q.rstS[1]) begin
      // reset pin high: link idle, programming mode left
      s_d.progEn    = 1'b0;
      s_d.normalRun = 1'b1;
      s_d.bitCnt    = 5'h00;
      s_d.miso      = 1'b0;
    end else begin
      s_d.normalRun = 1'b0;
      if (rise) begin
        // every rising edge advances framing, extra pulses slip it
        s_d.rxSh   = word;
        s_d.bitCnt = s_q.bitCnt + 5'h01;
        if (s_q.bitCnt[2:0] == 3'h7) begin
          s_d.txSh = lastRead ? rdByte : b4;
        end
      end
      if (fall) begin
        s_d.miso = s_q.txSh[7];
        s_d.txSh = {s_q.txSh[6:0], 1'b0};
      end
      if (exec && isEnable) begin
        s_d.progEn = 1'b1;
      end
      if (exec && s_q.progEn && isFuseWr) begin
        s_d.fuse = b4;
      end
      if (exec && s_q.progEn && isLockWr) begin
        s_d.lock = s_q.lock & b2[2:1];
      end
    end
    // self-timed writer drains the job fifo one byte at a time
    if (eraseNow) begin
      s_d.busyCnt = BUSY_W'(ERASE_WAIT);
      s_d.jobOn   = 1'b0;
    end else if (s_q.busyCnt != '0) begin
      s_d.busyCnt = s_q.busyCnt - 24'h00_0001;
      if (commit) begin
        s_d.jobOn = 1'b0;
      end
    end else if (jobOutValid) begin
      s_d.jobOn   = 1'b1;
      s_d.jobTgt  = jobOutData[JOB_W-1];
      s_d.jobAddr = jobOutData[JOB_W-2:8];
      s_d.jobData = jobOutData[7:0];
      s_d.busyCnt = BUSY_W'(PROG_WAIT);
    end
    s_d.busy = (s_d.busyCnt != '0);
  end

  // state register
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_q           <= '0;
      s_q.rstS      <= 2'h3;
      s_q.normalRun <= 1'b1;
      s_q.lock      <= LOCK_RST;
      s_q.fuse      <= FUSE_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // arrays: whole-chip erase, or one committed byte (auto-erased)
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (eraseNow) begin
      for (int i = 0; i < PMEM_BYTES; i++) begin
        pmem[i] <= BYTE_ERASED;
      end
      for (int i = 0; i < DMEM_BYTES; i++) begin
        dmem[i] <= BYTE_ERASED;
      end
    end else if (commit) begin
      if (s_q.jobTgt == TGT_PMEM) begin
        pmem[s_q.jobAddr] <= s_q.jobData;
      end else begin
        dmem[s_q.jobAddr[DMEM_AW-1:0]] <= s_q.jobData;
      end
    end
  end

  // write jobs wait here while a byte is being programmed
  job_fifo #(
    .WIDTH (JOB_W),
    .DEPTH (FIFO_DEPTH)
  ) u_jobs (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .inValid  (jobInValid),
    .inReady  (jobInReady),
    .inData   (jobInData),
    .outValid (jobOutValid),
    .outReady (jobOutReady),
    .outData  (jobOutData)
  );

  // outputs straight from the state register
  assign miso        = s_q.miso;
  assign progEnabled = s_q.progEn;
  assign writeBusy   = s_q.busy;
  assign normalRun   = s_q.normalRun;
  assign fuseBits    = s_q.fuse;
  assign lockBits    = s_q.lock;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  a_enable_reset_low: assert property (
    $rose(s_q.progEn) |-> $past(!s_q.rstS[1] && isEnable && exec))
    else $error("programming enabled without enable instruction at reset low");

  a_enable_opcode: assert property (
    (exec && !s_q.rstS[1] && isEnable) |=> s_q.progEn)
    else $error("enable instruction not honoured");

  a_rx_on_rise: assert property (
    (rise && !s_q.rstS[1]) |=> s_q.rxSh[0] == $past(s_q.mosiS[1]))
    else $error("inbound bit not taken on rising link clock");

  a_tx_on_fall: assert property (
    !$stable(s_q.miso) |-> $past(fall) || $past(s_q.rstS[1]))
    else $error("outbound bit changed away from a falling link clock");

  a_echo_byte: assert property (
    (rise && !s_q.rstS[1] && s_q.bitCnt == 5'h0f) |=> s_q.txSh == $past(b4))
    else $error("second byte not echoed during third byte");

  a_erase_timer: assert property (
    eraseNow |=> s_q.busy && s_q.busyCnt == BUSY_W'(ERASE_WAIT))
    else $error("chip erase did not start the erase timer");

  a_poll_all_ones: assert property (
    (lastRead && !s_q.rstS[1] && pollHit) |=> s_q.txSh == BYTE_ERASED)
    else $error("byte under programming did not read as all ones");

  a_sig_locked: assert property (
    (lastRead && !s_q.rstS[1] && s_q.progEn && b1 == OP_SIG_RD
     && s_q.lock == LOCK_MODE3) |=> s_q.txSh == 8'h00)
    else $error("signature readable in lock mode 3");

  a_lock_one_way: assert property (
    ##1 (s_q.lock & ~$past(s_q.lock)) == 2'h0)
    else $error("lock bit returned to unprogrammed");

  a_reset_pin_leaves: assert property (
    s_q.rstS[1] |=> !s_q.progEn && s_q.bitCnt == 5'h00 && s_q.normalRun)
    else $error("programming mode kept with reset pin high");

  a_bit_framing: assert property (
    (rise && !s_q.rstS[1]) |=> s_q.bitCnt == $past(s_q.bitCnt) + 5'h01)
    else $error("framing did not advance on a link clock edge");

  c_enable: cover property ($rose(s_q.progEn));
  c_erase: cover property (eraseNow);
  c_commit: cover property (commit);
  c_poll: cover property (lastRead && pollHit);

endmodule
`default_nettype wire

// ==== tb/programmer_model.sv ====
// programmer model: drives link clock, link data and reset pin of the loader
// assumes ref_clk at 50 MHz; pins change on falling ref_clk, link clock 160 ns
`timescale 1ns/100ps
`default_nettype none
module programmer_model (
  input  wire logic ref_clk,
  input  wire logic miso,
  output logic      sckPin,
  output logic      mosiPin,
  output logic      resetPinN
);
  // ----------------------------------------------------------------
  // power-up levels
  // ----------------------------------------------------------------
  // reset and link clock low from the start
  initial begin
    sckPin    = 1'b0;
    mosiPin   = 1'b0;
    resetPinN = 1'b0;
  end

  // ----------------------------------------------------------------
  // link tasks
  // ----------------------------------------------------------------
  // one link clock phase, four oscillator cycles
  task automatic phase();
    repeat (4) @(negedge ref_clk);
  endtask

  // one instruction, all four bytes, msb first
  task automatic xfer(input logic [31:0] tx, output logic [31:0] rx);
    for (int i = 31; i >= 0; i--) begin
      mosiPin = tx[i];
      phase();
      rx[i]  = miso;
      sckPin = 1'b1;
      phase();
      sckPin = 1'b0;
    end
    mosiPin = ~tx[0]; // released line shows the inverse
    phase();
  endtask

  // single stray clock pulse to move the framing
  task automatic extraPulse();
    sckPin = 1'b1;
    phase();
    sckPin = 1'b0;
    phase();
  endtask

  // reset pin level, held eight oscillator cycles
  task automatic setReset(input logic level);
    resetPinN = level;
    repeat (8) @(negedge ref_clk);
  endtask
endmodule
`default_nettype wire

// ==== tb/testbench.sv ====
// self-checking bench of the serial program loader, tests as instruction sequences
// assumes programmer_model drives the link; write timers shortened by parameter
`timescale 1ns/100ps
`default_nettype none
module testbench;
  localparam int unsigned PW  = 3000;
  localparam logic [31:0] SIG = prog_loader_pkg::SIG_RST; // signature the design ships with
  localparam logic [7:0]  CAL = prog_loader_pkg::CAL_RST; // calibration the design ships with
  logic        ref_clk;
  logic        rst;
  logic        sckPin;
  logic        mosiPin;
  logic        resetPinN;
  logic        miso;
  logic        progEnabled;
  logic        writeBusy;
  logic        normalRun;
  logic [7:0]  fuseBits;
  logic [1:0]  lockBits;
  logic [31:0] rx;
  logic [31:0] wr [5];
  int          numErrors;
  int          compares;

  serial_program_loader #(.PROG_WAIT(PW), .ERASE_WAIT(500))
    serial_program_loader_inst (.ref_clk(ref_clk), .rst(rst), .sckPin(sckPin), .mosiPin(mosiPin),
    .resetPinN(resetPinN), .miso(miso), .progEnabled(progEnabled), .writeBusy(writeBusy),
    .normalRun(normalRun), .fuseBits(fuseBits), .lockBits(lockBits));
  programmer_model programmer_model_inst (.ref_clk(ref_clk), .miso(miso), .sckPin(sckPin),
    .mosiPin(mosiPin), .resetPinN(resetPinN));

  // ----------------------------------------------------------------
  // clock, watchdog and helpers
  // ----------------------------------------------------------------
  // 50 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  // cuts a hang short
  initial begin
    #2_000_000;
    numErrors++;
    $display("watchdog expired");
    wrap_up();
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      numErrors++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cmd(input logic [31:0] tx);
    programmer_model_inst.xfer(tx, rx);
  endtask

  task automatic rd(input logic [31:0] tx, input logic [7:0] exp);
    cmd(tx);
    check(rx[7:0], exp);
  endtask

  task automatic waitIdle();
    for (int n = 0; n < 5000 && writeBusy !== 1'b0; n++) @(negedge ref_clk);
    check({7'h0, writeBusy}, 8'h00);
  endtask

  task automatic wrap_up();
    $display("comparisons %0d, mismatches %0d", compares, numErrors);
    if (numErrors == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------
  // reset, enable, erase, memories, job queue, fuses and locks
  initial begin
    rst       = 1'b1;
    numErrors = 0;
    compares  = 0;
    wr = '{32'h4000_0012, 32'h4801_ff5a, 32'hc000_0056, 32'hc000_3fa5, 32'hc000_3f0f};
    repeat (5) @(negedge ref_clk);
    check({7'h0, normalRun}, 8'h01);
    check({7'h0, progEnabled}, 8'h00);
    check(fuseBits, 8'hff);
    check({6'h0, lockBits}, 8'h03);
    rst = 1'b0;
    repeat (6) @(negedge ref_clk); // settle before enabling, scaled down
    check({7'h0, normalRun}, 8'h00);
    cmd(32'hac80_0000);
    check({7'h0, writeBusy}, 8'h00);
    cmd(32'haca0_005a);
    check(fuseBits, 8'hff);
    cmd(32'hac53_0000);
    check(rx[15:8], 8'h53);
    check({7'h0, progEnabled}, 8'h01);
    $display("test enable done");
    cmd(32'hc000_3fa5);
    waitIdle();
    cmd(32'hac80_0000);
    check({7'h0, writeBusy}, 8'h01);
    waitIdle();
    programmer_model_inst.setReset(1'b1);
    check({7'h0, normalRun}, 8'h01);
    check({7'h0, progEnabled}, 8'h00);
    programmer_model_inst.setReset(1'b0);
    programmer_model_inst.extraPulse();
    cmd(32'hac53_0000);
    check(rx[16:9], 8'h29);
    check({7'h0, progEnabled}, 8'h00);
    programmer_model_inst.setReset(1'b1);
    programmer_model_inst.setReset(1'b0);
    cmd(32'hac53_0000);
    check(rx[15:8], 8'h53);
    rd(32'ha000_3f00, 8'hff);
    rd(32'h2801_ff00, 8'hff);
    $display("test erase done");
    for (int i = 0; i < 5; i++) begin
      cmd(wr[i]);
      rd({wr[i][31:24] - 8'h20, wr[i][23:8], 8'h00}, 8'hff);
      waitIdle();
      rd({wr[i][31:24] - 8'h20, wr[i][23:8], 8'h00}, wr[i][7:0]);
    end
    rd(32'h2001_ff00, 8'hff);
    // overwrite a stored byte with all ones: no polling, fixed wait
    cmd(32'hc000_1000);
    waitIdle();
    rd(32'ha000_1000, 8'h00);
    cmd(32'hc000_10ff);
    repeat (PW + 20) @(negedge ref_clk);
    check({7'h0, writeBusy}, 8'h00);
    rd(32'ha000_1000, 8'hff);
    $display("test memories done");
    for (int i = 0; i < 10; i++) begin
      cmd({16'hc000, 8'h20 + 8'(i), 8'h30 + 8'(i)});
    end
    repeat (9 * (PW + 20)) @(negedge ref_clk);
    waitIdle();
    for (int i = 0; i < 10; i++) begin
      rd({16'ha000, 8'h20 + 8'(i), 8'h00}, (i < 9) ? 8'h30 + 8'(i) : 8'hff);
    end
    $display("test job queue done");
    cmd(32'haca0_005a);
    check(fuseBits, 8'h5a);
    rd(32'h5000_0000, 8'h5a);
    rd(32'h5800_0000, 8'h06);
    rd(32'h3000_4000, SIG[15:8]);
    rd(32'h3800_0000, CAL);
    cmd(32'hacfd_0000);
    check({6'h0, lockBits}, 8'h02);
    rd(32'h5800_0000, 8'h04);
    rd(32'h3000_4000, SIG[15:8]);
    cmd(32'hacf9_0000);
    rd(32'h5800_0000, 8'h00);
    rd(32'h3000_4000, 8'h00);
    programmer_model_inst.setReset(1'b1);
    check({7'h0, normalRun}, 8'h01);
    $display("test fuses and locks done");
    wrap_up();
  end
endmodule
`default_nettype wire
